/* File: rtl/ocal_top.sv */
// optical emitter auto-calibration controller with trip outputs and register port
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module ocal_top #(
    parameter int BLINK_HALF_CYCLES = ocal_pkg::BLINK_HALF_CYC,
    parameter int SAMPLE_CYCLES = ocal_pkg::SAMPLE_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic cal_n_i,
    input wire logic clear_n_i,
    input wire logic [7:0] rx_level_i,
    input wire ocal_pkg::ocal_nv_type nv_i,
    input wire ocal_pkg::ocal_bus_type bus_i,
    output logic [7:0] drive_o,
    output ocal_pkg::ocal_nv_type nv_o,
    output logic nv_wr_o,
    output logic led_ok_o,
    output logic led_fail_o,
    output logic led_blue_o,
    output logic led_low_o,
    output logic trip_hi_o,
    output logic trip_lo_o,
    output logic [31:0] rdata_o,
    output logic irq_o
);
    import ocal_pkg::*;

    // a parameter only so that a full ramp to the ceiling fits in a short run
    localparam logic [11:0] SAMPLE_END = 12'(SAMPLE_CYCLES - 1);

    ocal_state_type state_r;
    logic [7:0] drive_r;
    logic restore_r;
    logic cal_prev_r;
    logic [11:0] sample_cnt_r;
    logic tick;
    logic sw_start;
    logic sw_clear;
    logic start_req;
    logic clr_req;
    logic at_target;
    logic ramp_tick;
    logic lock_evt;
    logic fail_evt;
    logic trip_hi_r;
    logic trip_lo_r;
    logic trip_hi_nxt;
    logic trip_lo_nxt;
    logic [STAT_W-1:0] status_r;
    logic [STAT_W-1:0] mask_r;
    logic [STAT_W-1:0] evt;
    logic [STAT_W-1:0] w1c;
    logic [31:0] rdata_r;
    ocal_nv_type nv_r;
    logic nv_wr_r;
    logic blink_busy;

    // software pulses share the pin paths so both behave the same
    assign sw_start = bus_i.wr && (bus_i.addr == ADDR_CTRL) && bus_i.wdata[CTRL_START_BIT];
    assign sw_clear = bus_i.wr && (bus_i.addr == ADDR_CTRL) && bus_i.wdata[CTRL_CLEAR_BIT];
    assign start_req = (cal_prev_r && !cal_n_i) || sw_start; // R1
    assign clr_req = !clear_n_i || sw_clear; // R5
    assign at_target = rx_level_i >= TARGET_LVL; // R3
    assign tick = sample_cnt_r == SAMPLE_END;
    assign ramp_tick = (state_r == S_RAMP) && tick && !clr_req && !start_req;
    assign lock_evt = ramp_tick && at_target; // R2
    assign fail_evt = ramp_tick && !at_target && (drive_r == DRIVE_MAX_CODE); // R6

    // falling edge of calibrate; idle high, so a low held through reset counts as a pulse at release
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cal_prev_r <= 1'b1;
        end else begin
            cal_prev_r <= cal_n_i;
        end
    end

    // sampling period divider, restarted with each run
    always_ff @(posedge clk_i) begin
        if (srst_i || start_req || tick) begin
            sample_cnt_r <= 12'h000;
        end else begin
            sample_cnt_r <= sample_cnt_r + 12'h001;
        end
    end

    // calibration sequencer; clear outranks calibrate
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_r <= S_IDLE;
            drive_r <= DRIVE_MIN_CODE;
            restore_r <= 1'b1;
        end else if (clr_req) begin
            state_r <= S_IDLE; // R5
            drive_r <= DRIVE_MIN_CODE;
            restore_r <= 1'b0;
        end else if (start_req) begin
            state_r <= S_RAMP; // R1
            drive_r <= DRIVE_MIN_CODE; // R1
            restore_r <= 1'b0;
        end else if (restore_r) begin
            // stored setting taken once, the cycle after reset release
            restore_r <= 1'b0;
            if (nv_i.valid) begin
                state_r <= S_LOCK; // R7
                drive_r <= nv_i.code; // R7
            end
        end else begin
            case (state_r)
                S_RAMP: begin
                    if (tick) begin
                        if (at_target) begin
                            state_r <= S_LOCK; // R2
                        end else if (drive_r == DRIVE_MAX_CODE) begin
                            state_r <= S_FAIL; // R6
                        end else begin
                            drive_r <= drive_r + 8'h01; // R12
                        end
                    end
                end
                default: begin
                    state_r <= state_r;
                end
            endcase
        end
    end

    assign drive_o = drive_r;

    // non-volatile record: written on lock, invalidated on clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            nv_r <= '0;
            nv_wr_r <= 1'b0;
        end else begin
            nv_wr_r <= lock_evt || clr_req; // R7
            if (clr_req) begin
                nv_r <= '0;
            end else if (lock_evt) begin
                nv_r.valid <= 1'b1; // R7
                nv_r.code <= drive_r;
            end
        end
    end

    assign nv_o = nv_r;
    assign nv_wr_o = nv_wr_r;

    ocal_blink #(
        .HALF_CYC(BLINK_HALF_CYCLES)
    ) u_blink (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .start_i(lock_evt),
        .abort_i(clr_req || start_req),
        .led_o(led_ok_o),
        .busy_o(blink_busy)
    );

    assign led_fail_o = state_r == S_FAIL; // R6

    // trip comparators, registered; no hysteresis beyond the two levels
    assign trip_hi_nxt = rx_level_i > TRIP_HI_LVL;
    assign trip_lo_nxt = rx_level_i < TRIP_LO_LVL;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            trip_hi_r <= 1'b0;
            trip_lo_r <= 1'b0;
        end else begin
            trip_hi_r <= trip_hi_nxt; // R8
            trip_lo_r <= trip_lo_nxt; // R9
        end
    end

    assign trip_hi_o = trip_hi_r;
    assign trip_lo_o = trip_lo_r;
    assign led_blue_o = trip_hi_r; // R10
    assign led_low_o = trip_lo_r; // R10

    // sticky status, a new event beats a same-cycle clear
    always_comb begin
        evt = '0;
        evt[STAT_DONE_BIT] = lock_evt;
        evt[STAT_FAIL_BIT] = fail_evt;
        evt[STAT_HI_BIT] = trip_hi_nxt && !trip_hi_r;
        evt[STAT_LO_BIT] = trip_lo_nxt && !trip_lo_r;
    end

    assign w1c = (bus_i.wr && (bus_i.addr == ADDR_STATUS)) ? bus_i.wdata[STAT_W-1:0] : '0;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            status_r <= STAT_RESET;
        end else begin
            status_r <= (status_r & ~w1c) | evt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mask_r <= STAT_RESET;
        end else if (bus_i.wr && (bus_i.addr == ADDR_MASK)) begin
            mask_r <= bus_i.wdata[STAT_W-1:0];
        end
    end

    assign irq_o = |(status_r & mask_r);

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_r <= 32'h00000000;
        end else if (!bus_i.rd) begin
            rdata_r <= 32'h00000000;
        end else if (bus_i.addr == ADDR_STATUS) begin
            rdata_r <= {28'h0000000, status_r};
        end else if (bus_i.addr == ADDR_MASK) begin
            rdata_r <= {28'h0000000, mask_r};
        end else if (bus_i.addr == ADDR_DRIVE) begin
            rdata_r <= {21'h00000, state_r == S_FAIL, state_r == S_RAMP,
                        state_r == S_LOCK, drive_r};
        end else if (bus_i.addr == ADDR_LEVEL) begin
            rdata_r <= {22'h00000, trip_lo_r, trip_hi_r, rx_level_i};
        end else begin
            rdata_r <= 32'h00000000;
        end
    end

    assign rdata_o = rdata_r;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    sequence seq_ramp_step;
        ramp_tick && !at_target && (drive_r != DRIVE_MAX_CODE);
    endsequence

    sequence seq_reach;
        ramp_tick && at_target;
    endsequence

    sequence seq_exhaust;
        ramp_tick && !at_target && (drive_r == DRIVE_MAX_CODE);
    endsequence

    sequence seq_restore;
        restore_r && nv_i.valid && !clr_req && !start_req;
    endsequence

    a_cal_start: assert property ( // R1
        (start_req && !clr_req) |=> (state_r == S_RAMP) && (drive_r == DRIVE_MIN_CODE))
        else $error("calibrate did not restart the ramp at zero");

    a_ramp_step: assert property ( // R12
        seq_ramp_step |=> (drive_r == $past(drive_r) + 8'h01) && (state_r == S_RAMP))
        else $error("drive did not advance by one step");

    a_ramp_wait: assert property ( // R12
        ((state_r == S_RAMP) && !tick && !clr_req && !start_req) |=> $stable(drive_r))
        else $error("drive moved between samples");

    a_stop_target: assert property ( // R2
        seq_reach |=> (state_r == S_LOCK) && $stable(drive_r) && nv_wr_o)
        else $error("ramp did not stop at target");

    a_target_half: assert property ( // R3
        ramp_tick |=> ((state_r == S_LOCK) == ($past(rx_level_i) >= TARGET_LVL)))
        else $error("target is not mid supply");

    a_flash_start: assert property ( // R4
        seq_reach |=> led_ok_o && blink_busy)
        else $error("success light did not start flashing");

    a_lock_hold: assert property ( // R5
        ((state_r == S_LOCK) && !clr_req && !start_req) |=> (state_r == S_LOCK) && $stable(drive_r))
        else $error("locked drive changed without clear");

    a_clear_unlock: assert property ( // R5
        (!clear_n_i) |=> (state_r == S_IDLE) && (drive_r == DRIVE_MIN_CODE))
        else $error("clear did not release the lock");

    a_fail_red: assert property ( // R6
        fail_evt |=> led_fail_o ##1 (led_fail_o || $past(clr_req) || $past(start_req)))
        else $error("red light not lit at maximum drive");

    a_nv_store: assert property ( // R7
        lock_evt |=> nv_wr_o && nv_o.valid && (nv_o.code == $past(drive_r)))
        else $error("locked setting not stored");

    a_trip_upper: assert property ( // R8
        (rx_level_i > 8'hAA) |=> trip_hi_o)
        else $error("upper trip missed");

    a_trip_lower: assert property ( // R9
        (rx_level_i < 8'h55) |=> trip_lo_o)
        else $error("lower trip missed");

    a_trip_leds: assert property ( // R10
        (led_blue_o == trip_hi_o) && (led_low_o == trip_lo_o))
        else $error("trip lights disagree with trip outputs");

    a_irq_level: assert property (
        $rose(status_r[STAT_DONE_BIT]) && mask_r[STAT_DONE_BIT] |-> irq_o)
        else $error("unmasked event gave no interrupt");

    a_fail_enter: assert property ( // R6
        seq_exhaust |=> (state_r == S_FAIL) && $stable(drive_r) && !led_ok_o)
        else $error("ramp at ceiling did not fail");

    a_fail_hold: assert property ( // R6
        ((state_r == S_FAIL) && !clr_req && !start_req) |=> led_fail_o && $stable(drive_r))
        else $error("failed state did not hold");

    a_fail_flag: assert property ( // R6
        seq_exhaust |=> status_r[STAT_FAIL_BIT])
        else $error("failure not flagged in status");

    a_done_flag: assert property ( // R4
        seq_reach |=> status_r[STAT_DONE_BIT])
        else $error("success not flagged in status");

    a_drive_ceiling: assert property ( // R1
        ((state_r == S_RAMP) || (state_r == S_FAIL)) |-> (drive_r <= DRIVE_MAX_CODE))
        else $error("drive above ceiling");

    a_restore_lock: assert property ( // R7
        seq_restore |=> (state_r == S_LOCK) && (drive_r == $past(nv_i.code)))
        else $error("stored setting not restored");

    a_clear_forget: assert property ( // R7
        clr_req |=> nv_wr_o && !nv_o.valid)
        else $error("clear did not invalidate stored setting");

    a_clear_dark: assert property ( // R5
        clr_req |=> !led_ok_o && !led_fail_o)
        else $error("lights stayed on after clear");

    a_trip_upper_off: assert property ( // R8
        (rx_level_i <= TRIP_HI_LVL) |=> !trip_hi_o)
        else $error("upper trip set below its level");

    a_trip_lower_off: assert property ( // R9
        (rx_level_i >= TRIP_LO_LVL) |=> !trip_lo_o)
        else $error("lower trip set above its level");

    a_rdata_idle: assert property (
        !bus_i.rd |=> (rdata_o == 32'h00000000))
        else $error("read data outside a read");

    a_mask_write: assert property (
        (bus_i.wr && (bus_i.addr == ADDR_MASK)) |=> (mask_r == $past(bus_i.wdata[STAT_W-1:0])))
        else $error("mask write not taken");
endmodule

/* File: common/ocal_pkg.sv */
// constants, types and operation summary for the optical auto-calibration block
// Operation
// R1: a low pulse on calibrate starts a run, ramping emitter drive up from 0 mA toward 14 mA
// R2: the ramp stops as soon as the receiver level reaches the calibration target
// R3: the calibration target is half of the supply, as seen at the receiver
// R4: reaching the target flashes the green success light exactly three times
// R5: after success the drive is frozen until reset/clear is driven low (a calibrate pulse here also restarts the ramp from 0)
// R6: drive reaching its maximum without meeting the target turns the red light on
// R7: the locked setting is kept in non-volatile storage and restored at power-up
// R8: the upper trip output changes when the signal rises above two thirds of supply
// R9: the lower trip output changes when the signal falls below one third of supply
// R10: blue light follows the upper trip, the low green light follows the lower trip
// R11: the operating party should recalibrate now and then against aging and drift
// R12: drive steps once per sampling period, target checked after each step
package ocal_pkg;
    localparam int CLK_KHZ = 40000;
    localparam int LVL_FS = 256;
    localparam logic [7:0] TARGET_LVL = 8'(LVL_FS / 2);
    localparam logic [7:0] TRIP_HI_LVL = 8'((LVL_FS * 2) / 3);
    localparam logic [7:0] TRIP_LO_LVL = 8'(LVL_FS / 3);
    localparam int DRIVE_MIN_UA = 0;
    localparam int DRIVE_MAX_UA = 14000;
    localparam int DRIVE_STEP_UA = 56;
    localparam logic [7:0] DRIVE_MIN_CODE = 8'(DRIVE_MIN_UA / DRIVE_STEP_UA);
    localparam logic [7:0] DRIVE_MAX_CODE = 8'(DRIVE_MAX_UA / DRIVE_STEP_UA);
    localparam int SAMPLE_US = 100;
    localparam int SAMPLE_CYC = (SAMPLE_US * CLK_KHZ + 999) / 1000;
    localparam logic [11:0] SAMPLE_LAST = 12'(SAMPLE_CYC - 1);
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
    localparam logic [2:0] BLINK_COUNT = 3'h3;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_DRIVE = 8'h0C;
    localparam logic [7:0] ADDR_LEVEL = 8'h10;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_FAIL_BIT = 1;
    localparam int STAT_HI_BIT = 2;
    localparam int STAT_LO_BIT = 3;
    localparam int STAT_W = 4;
    localparam logic [STAT_W-1:0] STAT_RESET = 4'h0;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam int DRV_LOCK_BIT = 8;
    localparam int DRV_RAMP_BIT = 9;
    localparam int DRV_FAIL_BIT = 10;

    typedef enum logic [1:0] {
        S_IDLE,
        S_RAMP,
        S_LOCK,
        S_FAIL
    } ocal_state_type;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } ocal_nv_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ocal_bus_type;
endpackage

/* File: rtl/ocal_blink.sv */
// success light flasher: a fixed number of on/off flashes per start
`timescale 1ns/1ps
module ocal_blink #(
    parameter int HALF_CYC = ocal_pkg::BLINK_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic start_i,
    input wire logic abort_i,
    output logic led_o,
    output logic busy_o
);
    import ocal_pkg::*;

    localparam logic [23:0] HALF_LAST = 24'(HALF_CYC - 1);
    localparam logic [2:0] PHASE_LAST = 3'((BLINK_COUNT * 2) - 1);

    logic [23:0] cnt_r;
    logic [2:0] phase_r;
    logic busy_r;
    logic [2:0] flashes_r;
    logic led_d_r;

    // restart on a new start keeps the flash count whole
    always_ff @(posedge clk_i) begin
        if (srst_i || abort_i) begin
            busy_r <= 1'b0;
            cnt_r <= 24'h000000;
            phase_r <= 3'h0;
        end else if (start_i) begin
            busy_r <= 1'b1;
            cnt_r <= 24'h000000;
            phase_r <= 3'h0;
        end else if (busy_r) begin
            if (cnt_r == HALF_LAST) begin
                cnt_r <= 24'h000000;
                if (phase_r == PHASE_LAST) begin
                    busy_r <= 1'b0; // R4
                end else begin
                    phase_r <= phase_r + 3'h1;
                end
            end else begin
                cnt_r <= cnt_r + 24'h000001;
            end
        end
    end

    // even phases are lit
    assign led_o = busy_r && !phase_r[0]; // R4
    assign busy_o = busy_r;

    // helper: count flashes since the last start
    always_ff @(posedge clk_i) begin
        if (srst_i || start_i) begin
            flashes_r <= 3'h0;
            led_d_r <= 1'b0;
        end else begin
            led_d_r <= led_o;
            if (led_o && !led_d_r) begin
                flashes_r <= flashes_r + 3'h1;
            end
        end
    end

    a_blink_three: assert property (@(posedge clk_i) disable iff (srst_i) // R4
        ($fell(busy_r) && !abort_i && !$past(abort_i)) |-> (flashes_r == BLINK_COUNT))
        else $error("success light did not flash three times");
endmodule

/* File: test/ocal_optics.sv */
// emitter and receiver pair model: received level follows drive current
`timescale 1ns/1ps
module ocal_optics (
    input wire logic [7:0] drive_i,
    input wire logic [7:0] gain_i,
    input wire logic ovr_en_i,
    input wire logic [7:0] ovr_lvl_i,
    output logic [7:0] level_o
);
    logic [15:0] raw;
    assign raw = drive_i * gain_i;
    // phototransistor saturates at full supply, never wraps
    assign level_o = ovr_en_i ? ovr_lvl_i : ((raw > 16'h00FF) ? 8'hFF : raw[7:0]);
endmodule

/* File: test/optical_auto_calibration_test.sv */
// self-checking bench for the optical auto-calibration block
`timescale 1ns/1ps
module optical_auto_calibration_test;
    import ocal_pkg::*;
    logic clk_i, srst_i, cal_n_i, clear_n_i, ovr_en, nv_wr_o;
    logic led_ok_o, led_fail_o, led_blue_o, led_low_o, trip_hi_o, trip_lo_o, irq_o;
    logic [7:0] rx_level_i, drive_o, gain, ovr_lvl;
    logic [31:0] rdata_o;
    ocal_nv_type nv_i, nv_o, nv_mem;
    ocal_bus_type bus_i;
    int mismatches, n_compared, cycles, n_wait;
    // short sampling period so the full ramp to the ceiling fits the run
    localparam int SMP = 40;

    ocal_top #(.BLINK_HALF_CYCLES(8), .SAMPLE_CYCLES(SMP)) u_dut (.clk_i(clk_i),
        .srst_i(srst_i), .cal_n_i(cal_n_i),
        .clear_n_i(clear_n_i), .rx_level_i(rx_level_i), .nv_i(nv_i), .bus_i(bus_i),
        .drive_o(drive_o), .nv_o(nv_o), .nv_wr_o(nv_wr_o), .led_ok_o(led_ok_o),
        .led_fail_o(led_fail_o), .led_blue_o(led_blue_o), .led_low_o(led_low_o),
        .trip_hi_o(trip_hi_o), .trip_lo_o(trip_lo_o), .rdata_o(rdata_o), .irq_o(irq_o));
    ocal_optics u_optics (.drive_i(drive_o), .gain_i(gain), .ovr_en_i(ovr_en),
        .ovr_lvl_i(ovr_lvl), .level_o(rx_level_i));

    // stand-in for the non-volatile store, survives srst_i
    initial nv_mem = '0;
    always @(posedge clk_i) begin
        if (nv_wr_o === 1'b1) begin
            nv_mem <= nv_o;
        end
    end
    assign nv_i = nv_mem;

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic give_verdict();
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ceiling well above the roughly 20k cycles the sequence needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 50000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_i <= '0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_i <= '0;
        #1;
        chk(rdata_o, exp);
    endtask

    task automatic calib(input logic [7:0] g, input logic use_reg, input logic [7:0] expd);
        int n;
        int k;
        logic prev;
        @(posedge clk_i);
        gain <= g;
        ovr_en <= 1'b0;
        if (use_reg) begin
            wr(ADDR_CTRL, 32'h1);
        end else begin
            @(posedge clk_i);
            cal_n_i <= 1'b0;
            @(posedge clk_i);
            cal_n_i <= 1'b1;
        end
        n = 0;
        while (drive_o !== 8'h01 && n < 5000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk(n >= SMP - 1 && n <= SMP + 3, 1);
        while (led_ok_o !== 1'b1 && n < 40000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk(drive_o, expd);
        chk(nv_wr_o, 1);
        chk(nv_o, {1'b1, expd});
        k = 1;
        prev = 1'b1;
        repeat (120) begin
            @(posedge clk_i);
            #1;
            if (led_ok_o === 1'b1 && prev !== 1'b1) k++;
            prev = led_ok_o;
        end
        chk(k, 3);
        chk(led_ok_o, 0);
        rchk(ADDR_DRIVE, {21'h0, 3'b001, expd});
    endtask

    logic [7:0] lv [4] = '{8'd171, 8'd170, 8'd84, 8'd85};
    logic hi [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    logic lo [4] = '{1'b0, 1'b0, 1'b1, 1'b0};

    initial begin
        srst_i = 1'b1;
        cal_n_i = 1'b1;
        clear_n_i = 1'b1;
        bus_i = '0;
        gain = 8'h00;
        ovr_en = 1'b1;
        ovr_lvl = 8'h55;
        mismatches = 0;
        n_compared = 0;
        cycles = 0;
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        wait_n(2);
        chk({drive_o, led_ok_o, led_fail_o, irq_o}, 0);
        rchk(ADDR_MASK, 0);
        rchk(ADDR_STATUS, 0);
        rchk(ADDR_CTRL, 0);
        wr(8'h20, 32'hFF);
        rchk(8'h20, 0);
        rchk(ADDR_MASK, 0);
        // trip points on both sides of each threshold
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            ovr_lvl <= lv[i];
            wait_n(3);
            chk({trip_hi_o, led_blue_o}, {2{hi[i]}});
            chk({trip_lo_o, led_low_o}, {2{lo[i]}});
            rchk(ADDR_LEVEL, {22'h0, lo[i], hi[i], lv[i]});
        end
        rchk(ADDR_STATUS, 32'hC);
        wr(ADDR_MASK, 32'h4);
        wait_n(1);
        chk(irq_o, 1);
        wr(ADDR_STATUS, 32'h4);
        wait_n(1);
        chk(irq_o, 0);
        rchk(ADDR_STATUS, 32'h8);
        wr(ADDR_MASK, 32'h0);
        wr(ADDR_STATUS, 32'h8);
        rchk(ADDR_STATUS, 0);
        calib(8'd32, 1'b0, 8'h04);
        rchk(ADDR_STATUS, 32'h9);
        wr(ADDR_MASK, 32'h1);
        wait_n(1);
        chk(irq_o, 1);
        wr(ADDR_STATUS, 32'h9);
        wr(ADDR_MASK, 32'h0);
        // light falls away: lock must not chase it
        @(posedge clk_i);
        gain <= 8'h00;
        wait_n(9000);
        chk(drive_o, 8'h04);
        chk(led_fail_o, 0);
        @(posedge clk_i);
        srst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        wait_n(3);
        chk(drive_o, 8'h04);
        rchk(ADDR_DRIVE, 32'h104);
        @(posedge clk_i);
        clear_n_i <= 1'b0;
        @(posedge clk_i);
        clear_n_i <= 1'b1;
        wait_n(3);
        chk(drive_o, 0);
        chk(nv_mem.valid, 0);
        calib(8'd64, 1'b1, 8'h02);
        wr(ADDR_CTRL, 32'h2);
        wait_n(2);
        chk(drive_o, 0);
        rchk(ADDR_DRIVE, 0);
        // dark receiver: the ramp must run out and light the red lamp
        wr(ADDR_STATUS, 32'hF);
        @(posedge clk_i);
        gain <= 8'h00;
        wr(ADDR_CTRL, 32'h1);
        n_wait = 0;
        while (led_fail_o !== 1'b1 && n_wait < 300 * SMP) begin
            @(posedge clk_i);
            #1;
            n_wait++;
        end
        chk(n_wait, 251 * SMP);
        chk(drive_o, DRIVE_MAX_CODE);
        rchk(ADDR_DRIVE, {21'h0, 3'b100, DRIVE_MAX_CODE});
        rchk(ADDR_STATUS, 32'h2);
        wr(ADDR_CTRL, 32'h2);
        wait_n(1);
        chk(led_fail_o, 0);
        give_verdict();
    end
endmodule
